// *** src/led_cfg_consts.svh ***
// Offsets, field positions, reset values and geometry tables of the LED matrix configuration block
`ifndef LED_CFG_CONSTS_SVH
`define LED_CFG_CONSTS_SVH

// ----------------------------------------------------------------
// Register byte offsets on the register bus
// ----------------------------------------------------------------
`define OFF_CFG2_LO 12'h000
`define OFF_CFG2_HI 12'h004
`define OFF_CFG3_LO 12'h008
`define OFF_CFG3_HI 12'h00c
`define OFF_GEOM_STATUS 12'h010

// ----------------------------------------------------------------
// Writable masks and reset images of the two 48-bit words
// ----------------------------------------------------------------
`define CFG2_WR_MASK 48'hbf80_0000_0000
`define CFG2_RESET 48'h3b80_0000_0000
`define CFG3_WR_MASK 48'h007f_ffff_ffbf
`define CFG3_RESET 48'h003b_7f7f_7f00

// ----------------------------------------------------------------
// Field positions, second configuration word
// ----------------------------------------------------------------
`define RED_NOISE_BIT 39
`define GREEN_NOISE_BIT 40
`define BLUE_NOISE_BIT 41
`define SUBP_CAP_BIT 42
`define GEOM_LSB 43
`define GEOM_MSB 45
`define CFG2_RSVD_BIT 46
`define PSAVE_BIT 47

// ----------------------------------------------------------------
// Field positions, third configuration word
// ----------------------------------------------------------------
`define RED_OPEN_LSB 0
`define RED_OPEN_MSB 1
`define GREEN_OPEN_LSB 2
`define GREEN_OPEN_MSB 3
`define BLUE_OPEN_LSB 4
`define BLUE_OPEN_MSB 5
`define CFG3_RSVD_BIT 6
`define READBACK_BIT 7
`define RED_LEVEL_LSB 8
`define RED_LEVEL_MSB 15
`define GREEN_LEVEL_LSB 16
`define GREEN_LEVEL_MSB 23
`define BLUE_LEVEL_LSB 24
`define BLUE_LEVEL_MSB 31
`define GLOBAL_LEVEL_LSB 32
`define GLOBAL_LEVEL_MSB 34
`define SHORT_RM_LSB 35
`define SHORT_RM_MSB 38

// ----------------------------------------------------------------
// Field reset values
// ----------------------------------------------------------------
`define NOISE_RESET 1'b1
`define GEOM_RESET 3'h7
`define LEVEL_RESET 8'h7f
`define GLOBAL_RESET 3'h3
`define SHORT_RM_RESET 4'h7
`define OPEN_RESET 2'h0

// ----------------------------------------------------------------
// Geometry status word layout
// ----------------------------------------------------------------
`define ST_ORDER_LSB 0
`define ST_LEN_LSB 8
`define ST_REV_LSB 12
`define ST_CODE_LSB 16

// ----------------------------------------------------------------
// Geometry codes and their decode (order: slot 0 in bits 1:0, 0-based device index)
// ----------------------------------------------------------------
`define GEOM_16X16 3'h0
`define GEOM_32X32 3'h1
`define GEOM_48X48_D123 3'h2
`define GEOM_48X48_D132 3'h3
`define GEOM_48X64_D123 3'h4
`define GEOM_48X64_D132 3'h5
`define GEOM_64X64_D1234 3'h6
`define GEOM_64X64_D1423 3'h7
`define ORDER_D1 8'h00
`define ORDER_D12 8'h04
`define ORDER_D123 8'h24
`define ORDER_D132 8'h18
`define ORDER_D1234 8'he4
`define ORDER_D1423 8'h9c
`define REV_NONE 4'h0
`define REV_D3 4'h4
`define REV_D34 4'hc

// ----------------------------------------------------------------
// Bus responses
// ----------------------------------------------------------------
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// *** src/led_cfg_pkg.sv ***
// Types shared by the LED matrix configuration block
package led_cfg_pkg;

    // Register selected by a bus address
    typedef enum logic [2:0] {
        IDX_CFG2_LO,
        IDX_CFG2_HI,
        IDX_CFG3_LO,
        IDX_CFG3_HI,
        IDX_GEOM,
        IDX_NONE
    } reg_index_t;

    // Whole state of the bus slave and configuration storage
    typedef struct packed {
        logic aw_held;
        logic [11:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic b_valid;
        logic [1:0] b_resp;
        logic r_valid;
        logic [31:0] r_data;
        logic [1:0] r_resp;
        logic [47:0] cfg2;
        logic [47:0] cfg3;
    } slave_state_t;

    // Registered geometry decode
    typedef struct packed {
        logic [7:0] order;
        logic [2:0] length;
        logic [3:0] reversed;
    } geom_state_t;

endpackage

// *** src/geometry_decoder.sv ***
// Registered decode of the module geometry code into scan order, length and reversed devices
`timescale 1ns/1ps
`include "led_cfg_consts.svh"

module geometry_decoder (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [2:0] geometry_code,
    output logic [7:0] scan_order,
    output logic [2:0] scan_length,
    output logic [3:0] reversed_devices
);

    led_cfg_pkg::geom_state_t g_reg;
    led_cfg_pkg::geom_state_t g_next;

    // ----------------------------------------------------------------
    // Decode table
    // ----------------------------------------------------------------
    // Every code is legal, so no default branch
    always_comb begin
        g_next = g_reg;
        unique case (geometry_code)
            `GEOM_16X16: g_next = '{order: `ORDER_D1, length: 3'h1, reversed: `REV_NONE};
            `GEOM_32X32: g_next = '{order: `ORDER_D12, length: 3'h2, reversed: `REV_NONE};
            `GEOM_48X48_D123: g_next = '{order: `ORDER_D123, length: 3'h3, reversed: `REV_D3};
            `GEOM_48X48_D132: g_next = '{order: `ORDER_D132, length: 3'h3, reversed: `REV_D3};
            `GEOM_48X64_D123: g_next = '{order: `ORDER_D123, length: 3'h3, reversed: `REV_D34};
            `GEOM_48X64_D132: g_next = '{order: `ORDER_D132, length: 3'h3, reversed: `REV_D34};
            // Ambiguous code: the four-device straight order is taken
            `GEOM_64X64_D1234: g_next = '{order: `ORDER_D1234, length: 3'h4, reversed: `REV_D34};
            `GEOM_64X64_D1423: g_next = '{order: `ORDER_D1423, length: 3'h4, reversed: `REV_D34};
        endcase
    end

    // Reset image matches the decode of the reset geometry code
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            g_reg <= '{order: `ORDER_D1423, length: 3'h4, reversed: `REV_D34};
        end else begin
            g_reg <= g_next;
        end
    end

    assign scan_order = g_reg.order;
    assign scan_length = g_reg.length;
    assign reversed_devices = g_reg.reversed;

endmodule

// *** src/led_matrix_config_fields.sv ***
// Configuration storage for an LED matrix driver with an AXI4-Lite register slave
`timescale 1ns/1ps
`include "led_cfg_consts.svh"

// Operation
// [R01] Green group immunity bit 40, resets to 1; 0 high, 1 low immunity.
// [R02] Blue group immunity bit 41, resets to 1; 0 high, 1 low immunity.
// [R03] Bit 42, reset 0, caps subperiod count at 256 when set.
// [R04] Geometry field bits 45-43, reset 111b; 000b 16x16, 001b 32x32.
// [R05] Codes 010b/011b: 48x48, third device reversed, orders 1-2-3 and 1-3-2.
// [R06] Codes 100b/101b: 48x64, devices 3,4 reversed, orders 1-2-3 and 1-3-2.
// [R07] Codes 110b/111b: 64x64, devices 3,4 reversed; 111b scans 1-4-2-3.
// [R08] Bit 47, reset 0, turns matrix power saving on.
// [R09] Bits 1-0, reset 00b, pick red open-load threshold.
// [R10] Bits 3-2, reset 00b, pick green open-load threshold.
// [R11] Bits 5-4, reset 00b, pick blue open-load threshold.
// [R12] Bit 7, reset 0, enables fault result readback.
// [R13] Red colour level bits 15-8, resets to 127.
// [R14] Green colour level bits 23-16, resets to 127.
// [R15] Blue colour level bits 31-24, resets to 127.
// [R16] Global brightness bits 34-32, resets to 3.
// [R17] Red group immunity bit 39, resets to 1; 0 high, 1 low immunity.
// [R18] Short removal level bits 38-35, resets to 0111b.
// [R19] Fields hold until rewritten or reset; reserved bits read zero.
module led_matrix_config_fields (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [11:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output logic red_group_noise_select,
    output logic green_group_noise_select,
    output logic blue_group_noise_select,
    output logic subperiod_cap_enable,
    output logic [2:0] module_geometry,
    output logic matrix_power_save_enable,
    output logic [1:0] red_open_threshold,
    output logic [1:0] green_open_threshold,
    output logic [1:0] blue_open_threshold,
    output logic fault_readback_enable,
    output logic [7:0] red_colour_level,
    output logic [7:0] green_colour_level,
    output logic [7:0] blue_colour_level,
    output logic [2:0] global_brightness_level,
    output logic [3:0] short_removal_level,
    output logic [7:0] scan_order,
    output logic [2:0] scan_length,
    output logic [3:0] reversed_devices
);

    localparam led_cfg_pkg::slave_state_t STATE_RESET = '{
        cfg2: `CFG2_RESET,
        cfg3: `CFG3_RESET,
        default: '0
    };

    led_cfg_pkg::slave_state_t s_reg;
    led_cfg_pkg::slave_state_t s_next;
    logic wr_commit;
    logic [31:0] geom_status;

    // ----------------------------------------------------------------
    // Helper functions
    // ----------------------------------------------------------------

    // Address to register index; shared by the read and write paths
    function automatic led_cfg_pkg::reg_index_t decode_index(input logic [11:0] addr);
        led_cfg_pkg::reg_index_t idx;
        case (addr)
            `OFF_CFG2_LO: idx = led_cfg_pkg::IDX_CFG2_LO;
            `OFF_CFG2_HI: idx = led_cfg_pkg::IDX_CFG2_HI;
            `OFF_CFG3_LO: idx = led_cfg_pkg::IDX_CFG3_LO;
            `OFF_CFG3_HI: idx = led_cfg_pkg::IDX_CFG3_HI;
            `OFF_GEOM_STATUS: idx = led_cfg_pkg::IDX_GEOM;
            default: idx = led_cfg_pkg::IDX_NONE;
        endcase
        return idx;
    endfunction

    // Merge one bus word into a 48-bit image under byte strobes.
    // The mask drops reserved bits, so they can never be set by software.
    function automatic logic [47:0] apply_word(
        input logic [47:0] img,
        input logic hi,
        input logic [31:0] data,
        input logic [3:0] strb,
        input logic [47:0] mask
    );
        logic [63:0] wide;
        wide = {16'h0000, img};
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                wide[(hi ? 32 : 0) + 8 * i +: 8] = data[8 * i +: 8];
            end
        end
        return wide[47:0] & mask;
    endfunction

    // ----------------------------------------------------------------
    // Handshake outputs
    // ----------------------------------------------------------------
    // Address and data are held separately so either may arrive first;
    // neither is taken again until the response has been accepted.
    assign awready = !s_reg.aw_held && !s_reg.b_valid;
    assign wready = !s_reg.w_held && !s_reg.b_valid;
    assign arready = !s_reg.r_valid;
    assign wr_commit = s_reg.aw_held && s_reg.w_held && !s_reg.b_valid;

    // Read-only view of the registered geometry decode
    assign geom_status = {13'h0000, module_geometry, reversed_devices, 1'b0, scan_length, scan_order};

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        s_next = s_reg;
        // Capture write address and write data independently
        if (awvalid && awready) begin
            s_next.aw_held = 1'b1;
            s_next.aw_addr = awaddr;
        end
        if (wvalid && wready) begin
            s_next.w_held = 1'b1;
            s_next.w_data = wdata;
            s_next.w_strb = wstrb;
        end
        if (s_reg.b_valid && bready) begin
            s_next.b_valid = 1'b0;
        end
        // Commit once both halves are held; fields change only here
        if (wr_commit) begin
            s_next.aw_held = 1'b0;
            s_next.w_held = 1'b0;
            s_next.b_valid = 1'b1;
            s_next.b_resp = `RESP_OKAY;
            unique case (decode_index(s_reg.aw_addr))
                led_cfg_pkg::IDX_CFG2_LO: begin
                    s_next.cfg2 = apply_word(s_reg.cfg2, 1'b0, s_reg.w_data, s_reg.w_strb, `CFG2_WR_MASK); // R19
                end
                led_cfg_pkg::IDX_CFG2_HI: begin
                    s_next.cfg2 = apply_word(s_reg.cfg2, 1'b1, s_reg.w_data, s_reg.w_strb, `CFG2_WR_MASK); // R19
                end
                led_cfg_pkg::IDX_CFG3_LO: begin
                    s_next.cfg3 = apply_word(s_reg.cfg3, 1'b0, s_reg.w_data, s_reg.w_strb, `CFG3_WR_MASK); // R19
                end
                led_cfg_pkg::IDX_CFG3_HI: begin
                    s_next.cfg3 = apply_word(s_reg.cfg3, 1'b1, s_reg.w_data, s_reg.w_strb, `CFG3_WR_MASK); // R19
                end
                led_cfg_pkg::IDX_GEOM: begin
                    s_next.b_resp = `RESP_SLVERR; // Status is read-only
                end
                led_cfg_pkg::IDX_NONE: begin
                    s_next.b_resp = `RESP_SLVERR;
                end
            endcase
        end
        if (s_reg.r_valid && rready) begin
            s_next.r_valid = 1'b0;
        end
        // Read data is registered; upper halves carry word bits 47:32 in their low 16 bits, the rest read zero
        if (arvalid && arready) begin
            s_next.r_valid = 1'b1;
            s_next.r_resp = `RESP_OKAY;
            unique case (decode_index(araddr))
                led_cfg_pkg::IDX_CFG2_LO: s_next.r_data = s_reg.cfg2[31:0];
                led_cfg_pkg::IDX_CFG2_HI: s_next.r_data = {16'h0000, s_reg.cfg2[47:32]};
                led_cfg_pkg::IDX_CFG3_LO: s_next.r_data = s_reg.cfg3[31:0];
                led_cfg_pkg::IDX_CFG3_HI: s_next.r_data = {16'h0000, s_reg.cfg3[47:32]};
                led_cfg_pkg::IDX_GEOM: s_next.r_data = geom_status;
                led_cfg_pkg::IDX_NONE: begin
                    s_next.r_data = 32'h0000_0000;
                    s_next.r_resp = `RESP_SLVERR;
                end
            endcase
        end
    end

    // State register; reset loads documented field defaults
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_reg <= STATE_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    // ----------------------------------------------------------------
    // Bus answers
    // ----------------------------------------------------------------
    assign bvalid = s_reg.b_valid;
    assign bresp = s_reg.b_resp;
    assign rvalid = s_reg.r_valid;
    assign rdata = s_reg.r_data;
    assign rresp = s_reg.r_resp;

    // ----------------------------------------------------------------
    // Field outputs
    // ----------------------------------------------------------------
    // Second word: immunity, subperiod cap, geometry, power save
    assign red_group_noise_select = s_reg.cfg2[`RED_NOISE_BIT]; // R17
    assign green_group_noise_select = s_reg.cfg2[`GREEN_NOISE_BIT]; // R01
    assign blue_group_noise_select = s_reg.cfg2[`BLUE_NOISE_BIT]; // R02
    assign subperiod_cap_enable = s_reg.cfg2[`SUBP_CAP_BIT]; // R03
    assign module_geometry = s_reg.cfg2[`GEOM_MSB:`GEOM_LSB]; // R04
    assign matrix_power_save_enable = s_reg.cfg2[`PSAVE_BIT]; // R08

    // Third word: thresholds, readback, colour and global levels
    assign red_open_threshold = s_reg.cfg3[`RED_OPEN_MSB:`RED_OPEN_LSB]; // R09
    assign green_open_threshold = s_reg.cfg3[`GREEN_OPEN_MSB:`GREEN_OPEN_LSB]; // R10
    assign blue_open_threshold = s_reg.cfg3[`BLUE_OPEN_MSB:`BLUE_OPEN_LSB]; // R11
    assign fault_readback_enable = s_reg.cfg3[`READBACK_BIT]; // R12
    assign red_colour_level = s_reg.cfg3[`RED_LEVEL_MSB:`RED_LEVEL_LSB]; // R13
    assign green_colour_level = s_reg.cfg3[`GREEN_LEVEL_MSB:`GREEN_LEVEL_LSB]; // R14
    assign blue_colour_level = s_reg.cfg3[`BLUE_LEVEL_MSB:`BLUE_LEVEL_LSB]; // R15
    assign global_brightness_level = s_reg.cfg3[`GLOBAL_LEVEL_MSB:`GLOBAL_LEVEL_LSB]; // R16
    assign short_removal_level = s_reg.cfg3[`SHORT_RM_MSB:`SHORT_RM_LSB]; // R18

    // ----------------------------------------------------------------
    // Geometry decode
    // ----------------------------------------------------------------
    // Registered so the scan logic sees a clean value one cycle after the geometry field changes, two after the commit
    geometry_decoder geometry_decoder_i (
        .aclk(aclk),
        .aresetn(aresetn),
        .geometry_code(module_geometry), // R05 R06 R07
        .scan_order(scan_order),
        .scan_length(scan_length),
        .reversed_devices(reversed_devices)
    );

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    AST_GREEN_NOISE_RESET: assert property ($rose(aresetn) |-> green_group_noise_select == `NOISE_RESET) // R01
        else $error("green immunity not at reset value");
    AST_BLUE_NOISE_WRITE: assert property ( // R02
        wr_commit && decode_index(s_reg.aw_addr) == led_cfg_pkg::IDX_CFG2_HI && s_reg.w_strb[1]
        |=> blue_group_noise_select == $past(s_reg.w_data[`BLUE_NOISE_BIT - 32]))
        else $error("blue immunity write lost");
    AST_SUBP_CAP_WRITE: assert property ( // R03
        wr_commit && decode_index(s_reg.aw_addr) == led_cfg_pkg::IDX_CFG2_HI && s_reg.w_strb[1]
        |=> subperiod_cap_enable == $past(s_reg.w_data[`SUBP_CAP_BIT - 32]))
        else $error("subperiod cap write lost");
    AST_GEOM_RESET: assert property ($rose(aresetn) |-> module_geometry == `GEOM_RESET // R04
        && scan_order == `ORDER_D1423)
        else $error("geometry not at reset value");
    AST_GEOM_48X48: assert property ( // R05
        (module_geometry == `GEOM_48X48_D132) [*2] |-> scan_order == `ORDER_D132 && scan_length == 3'h3
        && reversed_devices == `REV_D3)
        else $error("48x48 decode wrong");
    AST_GEOM_48X64: assert property ( // R06
        (module_geometry == `GEOM_48X64_D123) [*2] |-> scan_order == `ORDER_D123 && reversed_devices == `REV_D34)
        else $error("48x64 decode wrong");
    AST_GEOM_64X64: assert property ( // R07
        module_geometry == `GEOM_64X64_D1423 && !wr_commit |=> scan_order == `ORDER_D1423 && scan_length == 3'h4)
        else $error("64x64 decode wrong");
    AST_PSAVE_WRITE: assert property ( // R08
        wr_commit && decode_index(s_reg.aw_addr) == led_cfg_pkg::IDX_CFG2_HI && s_reg.w_strb[1]
        |=> matrix_power_save_enable == $past(s_reg.w_data[`PSAVE_BIT - 32]))
        else $error("power save write lost");
    AST_RED_OPEN_WRITE: assert property ( // R09
        wr_commit && decode_index(s_reg.aw_addr) == led_cfg_pkg::IDX_CFG3_LO && s_reg.w_strb[0]
        |=> red_open_threshold == $past(s_reg.w_data[`RED_OPEN_MSB:`RED_OPEN_LSB]))
        else $error("red threshold write lost");
    AST_GREEN_OPEN_HOLD: assert property (!wr_commit |=> $stable(green_open_threshold)) // R10
        else $error("green threshold changed without write");
    AST_BLUE_OPEN_RESET: assert property ($rose(aresetn) |-> blue_open_threshold == `OPEN_RESET) // R11
        else $error("blue threshold not at reset value");
    AST_READBACK_WRITE: assert property ( // R12
        wr_commit && decode_index(s_reg.aw_addr) == led_cfg_pkg::IDX_CFG3_LO && s_reg.w_strb[0]
        |=> fault_readback_enable == $past(s_reg.w_data[`READBACK_BIT]))
        else $error("readback enable write lost");
    AST_RED_LEVEL_RESET: assert property ($rose(aresetn) |-> red_colour_level == `LEVEL_RESET) // R13
        else $error("red level not at reset value");
    AST_GREEN_LEVEL_WRITE: assert property ( // R14
        wr_commit && decode_index(s_reg.aw_addr) == led_cfg_pkg::IDX_CFG3_LO && s_reg.w_strb[2]
        |=> green_colour_level == $past(s_reg.w_data[`GREEN_LEVEL_MSB:`GREEN_LEVEL_LSB]))
        else $error("green level write lost");
    AST_BLUE_LEVEL_HOLD: assert property (!wr_commit |=> $stable(blue_colour_level)) // R15
        else $error("blue level changed without write");
    AST_GLOBAL_RESET: assert property ($rose(aresetn) |-> global_brightness_level == `GLOBAL_RESET) // R16
        else $error("global level not at reset value");
    AST_RED_NOISE_RESET: assert property ($rose(aresetn) |-> red_group_noise_select == `NOISE_RESET) // R17
        else $error("red immunity not at reset value");
    AST_SHORT_RM_RESET: assert property ($rose(aresetn) |-> short_removal_level == `SHORT_RM_RESET) // R18
        else $error("short removal not at reset value");
    AST_RESERVED_ZERO: assert property ( // R19
        !s_reg.cfg2[`CFG2_RSVD_BIT] && !s_reg.cfg3[`CFG3_RSVD_BIT] && s_reg.cfg2[31:0] == 32'h0000_0000
        && s_reg.cfg3[47:39] == 9'h000)
        else $error("reserved bit set");
    AST_UNMAPPED_READ: assert property ( // R19
        arvalid && arready && decode_index(araddr) == led_cfg_pkg::IDX_NONE
        |=> rvalid && rresp == `RESP_SLVERR && rdata == 32'h0000_0000)
        else $error("unmapped read not refused");

    // Fields land the cycle after the commit, under their strobes
    AST_NOISE_WRITE: assert property ( // R01 R17
        wr_commit && decode_index(s_reg.aw_addr) == led_cfg_pkg::IDX_CFG2_HI && s_reg.w_strb[1:0] == 2'h3
        |=> {green_group_noise_select, red_group_noise_select} == $past(s_reg.w_data[8:7]))
        else $error("immunity write lost");
    AST_OPEN_WRITE: assert property ( // R10 R11
        wr_commit && decode_index(s_reg.aw_addr) == led_cfg_pkg::IDX_CFG3_LO && s_reg.w_strb[0]
        |=> {blue_open_threshold, green_open_threshold} == $past(s_reg.w_data[5:2]))
        else $error("threshold write lost");
    AST_LEVEL_WRITE: assert property ( // R13 R15
        wr_commit && decode_index(s_reg.aw_addr) == led_cfg_pkg::IDX_CFG3_LO && s_reg.w_strb == 4'hf
        |=> red_colour_level == $past(s_reg.w_data[15:8]) && blue_colour_level == $past(s_reg.w_data[31:24]))
        else $error("colour level write lost");
    AST_CFG3_HI_WRITE: assert property ( // R16 R18
        wr_commit && decode_index(s_reg.aw_addr) == led_cfg_pkg::IDX_CFG3_HI && s_reg.w_strb[0]
        |=> {short_removal_level, global_brightness_level} == $past(s_reg.w_data[6:0]))
        else $error("global or short removal write lost");

    // A refused write must leave both words alone
    AST_REFUSED_WRITE: assert property ( // R19
        wr_commit && decode_index(s_reg.aw_addr) inside {led_cfg_pkg::IDX_GEOM, led_cfg_pkg::IDX_NONE}
        |=> bresp == `RESP_SLVERR && $stable(s_reg.cfg2) && $stable(s_reg.cfg3))
        else $error("refused write changed a field");

    // Main scenarios
    COV_WRITE_DONE: cover property (bvalid && bready && bresp == `RESP_OKAY);
    COV_READ_DONE: cover property (rvalid && rready && rresp == `RESP_OKAY);
    COV_GEOM_CHANGE: cover property ($changed(module_geometry) ##1 $changed(scan_order));
    COV_SLVERR: cover property (bvalid && bresp == `RESP_SLVERR);

endmodule

// *** tb/host.sv ***
// AXI4-Lite host model: issues register cycles and checks the answers
`timescale 1ns/1ps
module host (
    input wire logic aclk, output logic [11:0] awaddr, output logic awvalid, input wire logic awready,
    output logic [31:0] wdata, output logic [3:0] wstrb, output logic wvalid, input wire logic wready,
    input wire logic [1:0] bresp, input wire logic bvalid, output logic bready,
    output logic [11:0] araddr, output logic arvalid, input wire logic arready,
    input wire logic [31:0] rdata, input wire logic [1:0] rresp, input wire logic rvalid, output logic rready
);
    int miscompares = 0, check_count = 0;
    initial {awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready} = '0;
    task automatic chk(input logic [47:0] s, input logic [47:0] e);
        check_count++;
        if (s !== e) miscompares++;
        if (s !== e) $display("ERROR %0t seen %h want %h", $time, s, e);
    endtask
    // Readies are comb, so they are judged at the falling edge; released address and data lines carry inverted values, wstrb keeps its value
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e);
        logic ta, tw, tb;
        @(posedge aclk);
        {awaddr, wdata, wstrb, awvalid, wvalid, bready} <= {a, d, 7'h7f};
        do begin
            @(negedge aclk);
            {ta, tw, tb} = {awvalid && awready, wvalid && wready, bvalid};
            if (tb) chk(bresp, e);
            @(posedge aclk);
            if (ta) {awvalid, awaddr} <= {1'b0, ~a};
            if (tw) {wvalid, wdata} <= {1'b0, ~d};
        end while (!tb);
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [33:0] e);
        logic ta, tr;
        @(posedge aclk);
        {araddr, arvalid, rready} <= {a, 2'h3};
        do begin
            @(negedge aclk);
            {ta, tr} = {arvalid && arready, rvalid};
            if (tr) chk({rresp, rdata}, e);
            @(posedge aclk);
            if (ta) {arvalid, araddr} <= {1'b0, ~a};
        end while (!tr);
        rready <= 1'b0;
    endtask
endmodule

// *** tb/led_matrix_config_fields_bench.sv ***
// Self-checking bench for the LED matrix configuration block
`timescale 1ns/1ps
module led_matrix_config_fields_bench;
    logic aclk = 1'b0, aresetn = 1'b0, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, fault_readback_enable, matrix_power_save_enable;
    logic red_group_noise_select, green_group_noise_select, blue_group_noise_select, subperiod_cap_enable;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb, short_removal_level, reversed_devices;
    logic [1:0] bresp, rresp, red_open_threshold, green_open_threshold, blue_open_threshold;
    logic [2:0] module_geometry, global_brightness_level, scan_length;
    logic [7:0] red_colour_level, green_colour_level, blue_colour_level, scan_order;
    wire [45:0] fld = {matrix_power_save_enable, module_geometry, subperiod_cap_enable, blue_group_noise_select,
        green_group_noise_select, red_group_noise_select, short_removal_level, global_brightness_level,
        blue_colour_level, green_colour_level, red_colour_level, fault_readback_enable, blue_open_threshold,
        green_open_threshold, red_open_threshold};
    logic [31:0] msk [4] = '{32'h0, 32'hbf80, 32'hffffffbf, 32'h7f};
    logic [33:0] rst [5] = '{34'h0, 34'h3b80, 34'h7f7f7f00, 34'h3b, 34'h7c49c};
    logic [19:0] geo [8] = '{20'h00100, 20'h10204, 20'h24324, 20'h34318, 20'h4c324, 20'h5c318, 20'h6c4e4, 20'h7c49c};
    led_matrix_config_fields led_matrix_config_fields_i (.*);
    host host_i (.*);
    initial forever #4 aclk = ~aclk; // 125 MHz
    task automatic chk_reset;
        for (int i = 0; i < 5; i++) host_i.rd(12'(4 * i), rst[i]);
        host_i.chk(fld, {8'h77, 4'h7, 3'h3, 24'h7f7f7f, 7'h0});
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", host_i.check_count, host_i.miscompares);
        if (host_i.miscompares == 0 && host_i.check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Reset image, all-zero and all-one words, every geometry code, refused cycles, reset again
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        chk_reset;
        for (int p = 0; p < 2; p++) begin
            for (int i = 0; i < 4; i++) host_i.wr(12'(4 * i), {32{p[0]}}, 2'h0);
            for (int i = 0; i < 4; i++) host_i.rd(12'(4 * i), {2'h0, {32{p[0]}} & msk[i]});
            host_i.chk(fld, {46{p[0]}});
        end
        for (int g = 0; g < 8; g++) begin
            host_i.wr(12'h004, 32'(g) << 11, 2'h0);
            host_i.rd(12'h010, {14'h0, geo[g]});
        end
        host_i.wr(12'h010, 32'h0, 2'h2);
        host_i.wr(12'h014, 32'hffffffff, 2'h2);
        host_i.rd(12'h014, 34'h200000000);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        chk_reset;
        wrap_up;
    end
    // A hung handshake ends the run as a failure
    initial begin
        #40000;
        host_i.miscompares++;
        wrap_up;
    end
endmodule
